// ---- cache_event_counter_irq_mask_tb_top.sv ----
// Self-checking testbench of the cache event counter block
module cache_event_counter_irq_mask_tb_top;
  import cec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock and reset
  logic                   core_clk;
  logic                   rst_n;
  logic                   clk_en;
  // Register port
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic                   reg_nonsecure;
  logic [31:0]            reg_rdata;
  logic                   reg_decerr;
  // Events and error sources
  logic [15:1]            event_pulse;
  logic [15:1]            event_secure;
  logic                   secure_count_permit;
  logic [8:1]             err;
  // Interrupt outputs
  logic [CEC_IRQ_NUM-1:0] irq_out;
  logic                   counter_event_interrupt;
  logic                   combined_interrupt_out;
  int                     n_errors;
  int                     tests_run;

  // Small counter width so saturation is reached quickly
  cec_event_counter #(.CNT_W(4)) i_cec_event_counter (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_nonsecure(reg_nonsecure),
    .reg_rdata(reg_rdata), .reg_decerr(reg_decerr),
    .event_pulse(event_pulse), .event_secure(event_secure),
    .secure_count_permit(secure_count_permit),
    .next_level_decerr(err[8]), .next_level_slverr(err[7]),
    .data_ram_read_error(err[6]), .tag_ram_read_error(err[5]),
    .data_ram_write_error(err[4]), .tag_ram_write_error(err[3]),
    .data_ram_read_parity_error(err[2]),
    .tag_ram_read_parity_error(err[1]),
    .irq_out(irq_out), .counter_event_interrupt(counter_event_interrupt),
    .combined_interrupt_out(combined_interrupt_out));

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle register write; returns just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic ns = 1'b0);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_nonsecure <= ns;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // One-cycle register read; data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // One-cycle pulse on event source n
  task automatic ev(input int n, input logic sec);
    @(posedge core_clk);
    event_pulse[n] <= 1'b1;
    event_secure[n] <= sec;
    @(posedge core_clk);
    event_pulse <= '0;
    event_secure <= '0;
    #1;
  endtask : ev

  // Reset values and masking rights
  task automatic t_mask;
    rd(CEC_OFF_MASK, 32'h0);
    rd(CEC_OFF_CFG0, 32'h0);
    wr(CEC_OFF_MASK, 32'h0000_01ff, 1'b1);
    chk(32'(reg_decerr), 32'h1);
    rd(CEC_OFF_MASK, 32'h0);
    wr(CEC_OFF_MASK, 32'hffff_ffff);
    chk(32'(reg_decerr), 32'h0);
    rd(CEC_OFF_MASK, 32'h0000_01ff);
    wr(CEC_OFF_AUX, 32'h0800_0000);
    wr(CEC_OFF_MASK, 32'h0000_0000, 1'b1);
    chk(32'(reg_decerr), 32'h0);
    rd(CEC_OFF_MASK, 32'h0);
    // A write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(CEC_OFF_MASK, 32'h0000_01ff);
    clk_en <= 1'b1;
    rd(CEC_OFF_MASK, 32'h0);
    $display("test mask done");
  endtask : t_mask

  // Independent counting, modes and secure filtering
  task automatic t_count;
    wr(CEC_OFF_CTRL, 32'h1);
    wr(CEC_OFF_CFG0, 32'h0000_000d);                     // src 3, mode 01
    wr(CEC_OFF_CFG1, 32'h0000_0017);                     // src 5, mode 11
    ev(5, 1'b0);
    rd(CEC_OFF_RAW, 32'h0);
    ev(3, 1'b0);
    rd(CEC_OFF_RAW, 32'h1);
    ev(3, 1'b1);
    secure_count_permit <= 1'b1;
    ev(3, 1'b1);
    secure_count_permit <= 1'b0;
    rd(CEC_OFF_VAL0, 32'h2);
    rd(CEC_OFF_VAL1, 32'h1);
    wr(CEC_OFF_CFG1, 32'h0000_003f);                     // src 15, mode 11
    ev(14, 1'b0);
    ev(15, 1'b0);
    rd(CEC_OFF_VAL1, 32'h2);
    $display("test count done");
  endtask : t_count

  // Preload, saturation, overflow flag and counter reset
  task automatic t_sat;
    wr(CEC_OFF_CTRL, 32'h0);
    wr(CEC_OFF_CFG0, 32'h0000_0002);                     // src off, mode 10
    wr(CEC_OFF_VAL0, 32'h0000_000e);
    rd(CEC_OFF_VAL0, 32'he);
    wr(CEC_OFF_CFG0, 32'h0000_000e);                     // src 3, mode 10
    ev(3, 1'b0);
    rd(CEC_OFF_VAL0, 32'he);
    wr(CEC_OFF_CLEAR, 32'h0000_01ff);
    wr(CEC_OFF_CTRL, 32'h1);
    // Preload while counting on must be ignored
    wr(CEC_OFF_VAL0, 32'h0000_0005);
    rd(CEC_OFF_VAL0, 32'he);
    ev(3, 1'b0);
    rd(CEC_OFF_RAW, 32'h0);
    ev(3, 1'b0);
    rd(CEC_OFF_VAL0, 32'hf);
    rd(CEC_OFF_RAW, 32'h1);
    wr(CEC_OFF_MASK, 32'h1);
    chk(32'(counter_event_interrupt), 32'h1);
    wr(CEC_OFF_CTRL, 32'h3);
    rd(CEC_OFF_VAL0, 32'h0);
    rd(CEC_OFF_VAL1, 32'h2);
    wr(CEC_OFF_CTRL, 32'h5);
    rd(CEC_OFF_VAL1, 32'h0);
    rd(CEC_OFF_CTRL, 32'h1);
    $display("test saturate done");
  endtask : t_sat

  // Every error source through mask, status and clear
  task automatic t_err;
    wr(CEC_OFF_MASK, 32'h0);
    wr(CEC_OFF_CLEAR, 32'h0000_01ff);
    @(posedge core_clk);
    err[8] <= 1'b1;
    @(posedge core_clk);
    err <= '0;
    #1;
    chk(32'(combined_interrupt_out), 32'h0);
    rd(CEC_OFF_RAW, 32'h100);
    wr(CEC_OFF_CLEAR, 32'h0000_0100);
    wr(CEC_OFF_MASK, 32'h0000_01ff);
    for (int i = 1; i <= 8; i++) begin
      @(posedge core_clk);
      err[i] <= 1'b1;
      @(posedge core_clk);
      err <= '0;
      #1;
      chk(32'(irq_out), 32'h1 << i);
      chk(32'(combined_interrupt_out), 32'h1);
      rd(CEC_OFF_MSTAT, 32'h1 << i);
      wr(CEC_OFF_CLEAR, 32'h1 << i);
      rd(CEC_OFF_RAW, 32'h0);
    end
    $display("test errors done");
  endtask : t_err

  // Verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_nonsecure = 1'b0;
    event_pulse = '0;
    event_secure = '0;
    secure_count_permit = 1'b0;
    err = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_mask();
    t_count();
    t_sat();
    t_err();
    test_done();
  end
endmodule : cache_event_counter_irq_mask_tb_top

// ---- cec_event_counter.sv ----
// Two saturating cache event counters with interrupt mask and status
//
// Added by the designer: strobed register access and the register addresses.
module cec_event_counter
  import cec_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock, reset and clock enable
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic                   reg_nonsecure,
  output      logic [31:0]            reg_rdata,
  output      logic                   reg_decerr,
  // Cache events, one pulse per occurrence, with security flag
  input  wire logic [15:1]            event_pulse,
  input  wire logic [15:1]            event_secure,
  input  wire logic                   secure_count_permit,
  // Error sources
  input  wire logic                   next_level_decerr,
  input  wire logic                   next_level_slverr,
  input  wire logic                   data_ram_read_error,
  input  wire logic                   tag_ram_read_error,
  input  wire logic                   data_ram_write_error,
  input  wire logic                   tag_ram_write_error,
  input  wire logic                   data_ram_read_parity_error,
  input  wire logic                   tag_ram_read_parity_error,
  // Interrupt outputs
  output      logic [CEC_IRQ_NUM-1:0] irq_out,
  output      logic                   counter_event_interrupt,
  output      logic                   combined_interrupt_out
);

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [5:0]             cfg_r [2];
  logic [CNT_W-1:0]       cnt_r [2];
  logic [1:0]             cnt_inc;
  logic [1:0]             cnt_ovf;
  logic                   count_en_r;
  logic                   aux_nsw_r;
  logic [CEC_IRQ_NUM-1:0] mask_r;
  logic [CEC_IRQ_NUM-1:0] raw_r;
  logic [CEC_IRQ_NUM-1:0] raw_set;
  logic [CEC_IRQ_NUM-1:0] masked;
  logic [31:0]            rdata_r;
  logic                   decerr_r;
  logic [15:0]            ev_vec;
  logic [15:0]            sec_vec;
  logic                   wr_cfg0;
  logic                   wr_cfg1;
  logic                   wr_val0;
  logic                   wr_val1;
  logic                   wr_mask;
  logic                   wr_ctrl;
  logic                   wr_clear;
  logic                   wr_aux;
  logic                   mask_refused;
  logic                   aux_refused;

  // Write decode
  assign wr_cfg0  = reg_wr && (reg_addr == CEC_OFF_CFG0);
  assign wr_cfg1  = reg_wr && (reg_addr == CEC_OFF_CFG1);
  assign wr_val0  = reg_wr && (reg_addr == CEC_OFF_VAL0);
  assign wr_val1  = reg_wr && (reg_addr == CEC_OFF_VAL1);
  assign wr_mask  = reg_wr && (reg_addr == CEC_OFF_MASK);
  assign wr_ctrl  = reg_wr && (reg_addr == CEC_OFF_CTRL);
  assign wr_clear = reg_wr && (reg_addr == CEC_OFF_CLEAR);
  assign wr_aux   = reg_wr && (reg_addr == CEC_OFF_AUX);

  // Non-secure mask write without permission is refused
  assign mask_refused = wr_mask && reg_nonsecure && !aux_nsw_r;
  assign aux_refused  = wr_aux && reg_nonsecure;

  // Event vectors with slot zero meaning no source
  assign ev_vec  = {event_pulse, 1'b0};
  assign sec_vec = {event_secure, 1'b0};

  // Global count enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_en_r <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      count_en_r <= reg_wdata[CEC_CTRL_EN_BIT];
    end
  end

  // Auxiliary permission bit, secure writes only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_nsw_r <= 1'b0;
    end else if (clk_en && wr_aux && !aux_refused) begin
      aux_nsw_r <= reg_wdata[CEC_AUX_NSW_BIT];
    end
  end

  // Per-counter configuration, counting and saturation
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    logic [3:0] src;
    logic [1:0] mode;
    logic       hit;
    logic       wr_cfg;
    logic       wr_val;
    logic       rst_cnt;
    logic       irq_req;
    assign src     = cfg_r[i][CEC_SRC_MSB:CEC_SRC_LSB];
    assign mode    = cfg_r[i][CEC_MODE_MSB:CEC_MODE_LSB];
    assign wr_cfg  = (i == 0) ? wr_cfg0 : wr_cfg1;
    assign wr_val  = (i == 0) ? wr_val0 : wr_val1;
    assign rst_cnt = wr_ctrl &&
                     reg_wdata[(i == 0) ? CEC_CTRL_RST0_BIT
                                        : CEC_CTRL_RST1_BIT];
    // Selected event, secure ones only with permit
    assign hit = count_en_r && (src != CEC_SRC_OFF) && ev_vec[src] &&
                 (!sec_vec[src] || secure_count_permit);
    assign cnt_inc[i] = hit && (cnt_r[i] != CNT_MAX);
    assign cnt_ovf[i] = hit && (cnt_r[i] == CNT_MAX);

    // Configuration register
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_r[i] <= CEC_CFG_RST;
      end else if (clk_en && wr_cfg) begin
        cfg_r[i] <= reg_wdata[5:0];
      end
    end

    // Counter value with preload, reset and saturation
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_r[i] <= CEC_CNT_RST[CNT_W-1:0];
      end else if (clk_en) begin
        if (rst_cnt) begin
          cnt_r[i] <= CEC_CNT_RST[CNT_W-1:0];
        end else if (wr_val && ((src == CEC_SRC_OFF) || !count_en_r)) begin
          cnt_r[i] <= reg_wdata[CNT_W-1:0];
        end else if (cnt_inc[i]) begin
          cnt_r[i] <= cnt_r[i] + CNT_W'(1);
        end
      end
    end

    // Counter interrupt request by mode
    always_comb begin
      irq_req = 1'b0;
      unique case (mode)
        CEC_MODE_INCR:  irq_req = cnt_inc[i];
        CEC_MODE_OVFL:  irq_req = cnt_ovf[i];
        CEC_MODE_NONE:  irq_req = 1'b0;
        CEC_MODE_NONE2: irq_req = 1'b0;
      endcase
    end
  end : g_cnt

  // Raw status set sources
  always_comb begin
    raw_set                   = '0;
    raw_set[CEC_IRQ_CNT]      = g_cnt[0].irq_req || g_cnt[1].irq_req;
    raw_set[CEC_IRQ_TAG_PAR]  = tag_ram_read_parity_error;
    raw_set[CEC_IRQ_DATA_PAR] = data_ram_read_parity_error;
    raw_set[CEC_IRQ_TAG_WR]   = tag_ram_write_error;
    raw_set[CEC_IRQ_DATA_WR]  = data_ram_write_error;
    raw_set[CEC_IRQ_TAG_RD]   = tag_ram_read_error;
    raw_set[CEC_IRQ_DATA_RD]  = data_ram_read_error;
    raw_set[CEC_IRQ_SLVERR]   = next_level_slverr;
    raw_set[CEC_IRQ_DECERR]   = next_level_decerr;
  end

  // Raw status: clear by writing one, new event wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_r <= CEC_RAW_RST;
    end else if (clk_en) begin
      raw_r <= (raw_r & ~({CEC_IRQ_NUM{wr_clear}} &
                          reg_wdata[CEC_IRQ_NUM-1:0])) | raw_set;
    end
  end

  // Interrupt mask register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= CEC_MASK_RST;
    end else if (clk_en && wr_mask && !mask_refused) begin
      mask_r <= reg_wdata[CEC_IRQ_NUM-1:0];
    end
  end

  // Masked status and interrupt outputs
  assign masked                  = raw_r & mask_r;
  assign irq_out                 = masked;
  assign counter_event_interrupt = masked[CEC_IRQ_CNT];
  assign combined_interrupt_out  = |masked;

  // Read data, valid in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          CEC_OFF_CFG0:  rdata_r <= {26'h0, cfg_r[0]};
          CEC_OFF_CFG1:  rdata_r <= {26'h0, cfg_r[1]};
          CEC_OFF_VAL0:  rdata_r <= 32'(cnt_r[0]);
          CEC_OFF_VAL1:  rdata_r <= 32'(cnt_r[1]);
          CEC_OFF_MASK:  rdata_r <= {23'h0, mask_r};
          CEC_OFF_CTRL:  rdata_r <= {31'h0, count_en_r};
          CEC_OFF_RAW:   rdata_r <= {23'h0, raw_r};
          CEC_OFF_MSTAT: rdata_r <= {23'h0, masked};
          CEC_OFF_AUX:   rdata_r <= {4'h0, aux_nsw_r, 27'h0};
          default:       rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Error response, one cycle after a refused write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      decerr_r <= 1'b0;
    end else if (clk_en) begin
      decerr_r <= mask_refused || aux_refused;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_decerr = decerr_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  mask_reset_a: assert property ($rose(rst_n) |-> mask_r == '0)
    else $error("mask not cleared by reset");

  mask_refuse_a: assert property (
    clk_en && wr_mask && reg_nonsecure && !aux_nsw_r
    |=> $stable(mask_r) && reg_decerr)
    else $error("refused mask write changed mask");

  mask_write_a: assert property (
    clk_en && wr_mask && !reg_nonsecure
    |=> mask_r == $past(reg_wdata[CEC_IRQ_NUM-1:0]))
    else $error("secure mask write lost");

  comb_irq_a: assert property (
    combined_interrupt_out == (irq_out != '0))
    else $error("combined interrupt wrong");

  gate_irq_a: assert property (
    (irq_out & ~mask_r) == '0 &&
    counter_event_interrupt == irq_out[CEC_IRQ_CNT])
    else $error("masked source reached output");

  cnt_sat_a: assert property (
    cnt_r[0] == CNT_MAX && !(clk_en && (wr_ctrl || wr_val0))
    |=> cnt_r[0] == CNT_MAX)
    else $error("counter wrapped");

  cnt1_sat_a: assert property (
    cnt_r[1] == CNT_MAX && !(clk_en && (wr_ctrl || wr_val1))
    |=> cnt_r[1] == CNT_MAX)
    else $error("counter one wrapped");

  cnt_inc_a: assert property (
    clk_en && cnt_inc[0] && !wr_ctrl && !wr_val0
    |=> cnt_r[0] == $past(cnt_r[0]) + CNT_W'(1))
    else $error("counter missed increment");

  cnt_preload_a: assert property (
    clk_en && wr_val0 &&
    cfg_r[0][CEC_SRC_MSB:CEC_SRC_LSB] == CEC_SRC_OFF
    |=> cnt_r[0] == $past(reg_wdata[CNT_W-1:0]))
    else $error("preload lost");

  cnt_off_a: assert property (
    clk_en && cfg_r[1][CEC_SRC_MSB:CEC_SRC_LSB] == CEC_SRC_OFF &&
    !wr_val1 && !wr_ctrl |=> $stable(cnt_r[1]))
    else $error("disabled counter moved");

  sec_block_a: assert property (
    !secure_count_permit && event_pulse == event_secure |-> cnt_inc == 2'b0)
    else $error("secure event counted");

  gen_off_a: assert property (
    !count_en_r |-> cnt_inc == 2'b0)
    else $error("counting while globally disabled");

  incr_irq_a: assert property (
    clk_en && cnt_inc[0] && cfg_r[0][1:0] == CEC_MODE_INCR
    |=> raw_r[CEC_IRQ_CNT])
    else $error("increment not flagged");

  mode_off_a: assert property (
    cfg_r[0][1] == cfg_r[0][0] && cfg_r[1][1] == cfg_r[1][0]
    |-> !raw_set[CEC_IRQ_CNT])
    else $error("disabled mode raised interrupt");

  ovf_irq_a: assert property (
    clk_en && cnt_ovf[0] && cfg_r[0][1:0] == CEC_MODE_OVFL
    |=> raw_r[CEC_IRQ_CNT])
    else $error("overflow not flagged");

  clr_a: assert property (
    clk_en && wr_clear && reg_wdata[CEC_IRQ_SLVERR] && !next_level_slverr
    |=> !raw_r[CEC_IRQ_SLVERR])
    else $error("clear had no effect");

  ctrl_rd_a: assert property (
    clk_en && reg_rd && reg_addr == CEC_OFF_CTRL
    |=> reg_rdata[2:1] == 2'b00)
    else $error("reset bits read nonzero");

  val_rd_a: assert property (
    clk_en && reg_rd && reg_addr == CEC_OFF_VAL1
    |=> reg_rdata == 32'($past(cnt_r[1])))
    else $error("count value read wrong");

  mstat_rd_a: assert property (
    clk_en && reg_rd && reg_addr == CEC_OFF_MSTAT
    |=> reg_rdata == {23'h0, $past(raw_r & mask_r)})
    else $error("masked status read wrong");

  cnt_incr_c: cover property (clk_en && cnt_inc[0] && cfg_r[0][1:0] ==
                              CEC_MODE_INCR);
  cnt_ovf_c:  cover property (clk_en && cnt_ovf[0]);
  refuse_c:   cover property (clk_en && mask_refused);
  comb_c:     cover property ($rose(combined_interrupt_out));

endmodule : cec_event_counter

// ---- cec_pkg.sv ----
// Package with register map, field layout and reset values of the event counter block
package cec_pkg;

  // Register byte offsets
  localparam logic [7:0] CEC_OFF_CFG0      = 8'h00;
  localparam logic [7:0] CEC_OFF_CFG1      = 8'h04;
  localparam logic [7:0] CEC_OFF_VAL0      = 8'h08;
  localparam logic [7:0] CEC_OFF_VAL1      = 8'h0c;
  localparam logic [7:0] CEC_OFF_MASK      = 8'h10;
  localparam logic [7:0] CEC_OFF_CTRL      = 8'h14;
  localparam logic [7:0] CEC_OFF_RAW       = 8'h18;
  localparam logic [7:0] CEC_OFF_MSTAT     = 8'h1c;
  localparam logic [7:0] CEC_OFF_CLEAR     = 8'h20;
  localparam logic [7:0] CEC_OFF_AUX       = 8'h24;

  // Configuration register fields
  localparam int         CEC_SRC_LSB       = 2;
  localparam int         CEC_SRC_MSB       = 5;
  localparam int         CEC_MODE_LSB      = 0;
  localparam int         CEC_MODE_MSB      = 1;
  localparam logic [3:0] CEC_SRC_OFF       = 4'h0;
  localparam logic [1:0] CEC_MODE_NONE     = 2'h0;
  localparam logic [1:0] CEC_MODE_INCR     = 2'h1;
  localparam logic [1:0] CEC_MODE_OVFL     = 2'h2;
  localparam logic [1:0] CEC_MODE_NONE2    = 2'h3;

  // Control register fields
  localparam int         CEC_CTRL_EN_BIT   = 0;
  localparam int         CEC_CTRL_RST0_BIT = 1;
  localparam int         CEC_CTRL_RST1_BIT = 2;

  // Auxiliary control: non-secure mask write permission
  localparam int         CEC_AUX_NSW_BIT   = 27;

  // Interrupt source positions
  localparam int         CEC_IRQ_CNT       = 0;
  localparam int         CEC_IRQ_TAG_PAR   = 1;
  localparam int         CEC_IRQ_DATA_PAR  = 2;
  localparam int         CEC_IRQ_TAG_WR    = 3;
  localparam int         CEC_IRQ_DATA_WR   = 4;
  localparam int         CEC_IRQ_TAG_RD    = 5;
  localparam int         CEC_IRQ_DATA_RD   = 6;
  localparam int         CEC_IRQ_SLVERR    = 7;
  localparam int         CEC_IRQ_DECERR    = 8;
  localparam int         CEC_IRQ_NUM       = 9;

  // Reset values
  localparam logic [5:0] CEC_CFG_RST       = 6'h00;
  localparam logic [8:0] CEC_MASK_RST      = 9'h000;
  localparam logic [8:0] CEC_RAW_RST       = 9'h000;
  localparam logic [31:0] CEC_CNT_RST      = 32'h0000_0000;

endpackage : cec_pkg
